// [core/xfer_prio_pick.sv]
`timescale 1ns/10ps
module xfer_prio_pick
  import xfer_vec_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] req, // pending requests, bit 0 highest
  output logic hit, // any request pending
  output logic [5:0] idx // index of the winner
);
  // lowest index wins; loop runs downward so the last write is the winner
  always_comb begin
    hit = 1'b0;
    idx = 6'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        hit = 1'b1;
        idx = 6'(i);
      end
    end
  end
endmodule

// [core/xfer_vec_lookup.sv]
`timescale 1ns/10ps
// What this block does
// - the descriptor is mode a, source, mode b, destination, count a, count b in order.
// - on activation the pointer at the vector is read, then the descriptor from it.
// - a software activation uses vector address 0400 plus twice vector bits 6..0.
// - a vector entry is two bytes and gives only the low bits of the start address.
// - only the advanced 24-bit address mode is built.
// - a hardware source uses vector address 0400 plus twice its fixed number.
// - software activation wins, then hardware sources in table order, serial 4 tx last.
// - the converter-done request uses vector 28 and only when its enable is set.
// - enable positions with no source never start a transfer.
// - a set enable routes its source here, a clear one leaves it to the cpu; the converter position follows adc_done_enable instead.
module xfer_vec_lookup
  import xfer_vec_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [NUM_SRC-1:0] src_req, // hardware source requests, table order
  input wire logic [NUM_SRC-1:0] activation_enable_bit, // routing enables, table order
  input wire logic adc_done_request, // converter finished
  input wire logic adc_done_enable, // enable for the converter request
  input wire logic sw_enable, // software activation enable
  input wire logic [6:0] soft_vector_reg, // software vector number
  output logic [NUM_SRC-1:0] cpu_irq, // sources left to the cpu
  output logic rd_req, // bus read request
  output logic rd_word, // 1: 16-bit read, 0: 32-bit read
  output logic [23:0] rd_addr, // bus read address
  input wire logic rd_ack, // read data valid
  input wire logic [31:0] rd_data, // read data
  output logic busy, // a lookup is in progress
  output logic desc_valid, // descriptor ready, one-cycle pulse
  output logic desc_sw, // descriptor was for software activation
  output logic [5:0] desc_src, // winning hardware source index
  output logic [23:0] desc_start, // descriptor start address
  output logic desc_fault, // start address outside ram or misaligned
  output logic [31:0] transfer_mode_word_a, // descriptor word 0
  output logic [31:0] source_pointer_word, // descriptor word 1
  output logic [31:0] transfer_mode_word_b, // descriptor word 2
  output logic [31:0] dest_pointer_word, // descriptor word 3
  output logic [31:0] count_word_a, // descriptor word 4
  output logic [31:0] count_word_b, // descriptor word 5
  input wire logic desc_taken // executor accepted the descriptor
);
  typedef enum logic [1:0] {S_IDLE, S_VEC, S_DESC, S_HOLD} state_e;
  state_e state_q;
  logic [NUM_SRC-1:0] act_req;
  logic hw_hit;
  logic [5:0] hw_idx;
  logic [2:0] word_q;
  logic [23:0] start_q;
  logic [31:0] desc_q [DESC_WORDS];

  function automatic logic [15:0] vec_addr(input logic [6:0] num);
    vec_addr = VEC_BASE + {8'h00, num, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      act_req[i] = src_req[i] & activation_enable_bit[i];
    end
    act_req[ADC_SRC_IDX] = adc_done_request & adc_done_enable;
  end

  always_comb begin
    cpu_irq = src_req & ~activation_enable_bit;
    cpu_irq[ADC_SRC_IDX] = adc_done_request & ~adc_done_enable;
  end

  xfer_prio_pick #(.N(NUM_SRC)) u_pick (
    .req(act_req),
    .hit(hw_hit),
    .idx(hw_idx)
  );

  // ----------------------------------------------------------------
  // lookup sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      word_q <= 3'h0;
      start_q <= 24'h000000;
      rd_addr <= 24'h000000;
      desc_sw <= 1'b0;
      desc_src <= 6'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          word_q <= 3'h0;
          if (sw_enable) begin
            // software ahead of any hardware request
            desc_sw <= 1'b1;
            rd_addr <= {8'h00, vec_addr(soft_vector_reg)};
            state_q <= S_VEC;
          end else if (hw_hit) begin
            desc_sw <= 1'b0;
            desc_src <= hw_idx;
            rd_addr <= {8'h00, vec_addr(SRC_VEC[hw_idx])};
            state_q <= S_VEC;
          end
        end
        S_VEC: begin
          if (rd_ack) begin
            // 16-bit pointer, upper byte forced, advanced mode only
            start_q <= {DESC_UPPER, rd_data[15:0]};
            rd_addr <= {DESC_UPPER, rd_data[15:0]};
            state_q <= S_DESC;
          end
        end
        S_DESC: begin
          if (rd_ack) begin
            rd_addr <= rd_addr + 24'h000004;
            word_q <= word_q + 3'h1;
            if (word_q == W_CNT_B) begin
              state_q <= S_HOLD;
            end
          end
        end
        S_HOLD: begin
          if (desc_taken) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DESC_WORDS; i++) begin
        desc_q[i] <= 32'h00000000;
      end
    end else if (state_q == S_DESC && rd_ack) begin
      desc_q[word_q] <= rd_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      desc_valid <= 1'b0;
    end else begin
      desc_valid <= (state_q == S_DESC) && rd_ack && (word_q == W_CNT_B);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_req = (state_q == S_VEC) || (state_q == S_DESC);
  assign rd_word = (state_q == S_VEC);
  assign busy = (state_q != S_IDLE);
  assign desc_start = start_q;
  // flagged, not blocked: software owns placement, this only reports it
  assign desc_fault = (start_q < RAM_LO) || (start_q > RAM_HI)
    || ((start_q[1:0] & ALIGN_MASK) != 2'h0);
  assign transfer_mode_word_a = desc_q[W_MODE_A];
  assign source_pointer_word = desc_q[W_SRC];
  assign transfer_mode_word_b = desc_q[W_MODE_B];
  assign dest_pointer_word = desc_q[W_DST];
  assign count_word_a = desc_q[W_CNT_A];
  assign count_word_b = desc_q[W_CNT_B];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sw_vec_addr: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && sw_enable)
    |=> rd_addr == {8'h00, VEC_BASE + {8'h00, $past(soft_vector_reg), 1'b0}})
    else $error("software vector address wrong");
  a_sw_first: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && sw_enable && hw_hit) |=> desc_sw)
    else $error("hardware won over software");
  a_hw_vec_addr: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && !sw_enable && act_req[0]) |=> rd_addr == 24'h000420)
    else $error("source 0 vector address wrong");
  a_adc_gate: assert property (@(posedge core_clk) disable iff (rst)
    (adc_done_request && !adc_done_enable) |-> cpu_irq[ADC_SRC_IDX] && !act_req[ADC_SRC_IDX])
    else $error("converter request routed while disabled");
  a_adc_vec: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && !sw_enable && act_req == (NUM_SRC'(1) << ADC_SRC_IDX))
    |=> rd_addr == 24'h000438)
    else $error("converter vector address wrong");
  a_last_src: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && !sw_enable && act_req == (NUM_SRC'(1) << SERIAL4_TX_IDX))
    |=> rd_addr == 24'(VEC_BASE) + 24'(2 * SERIAL4_TX_VEC))
    else $error("last serial transmit vector address wrong");
  a_addr_hold: assert property (@(posedge core_clk) disable iff (rst)
    (rd_req && !rd_ack) |=> $stable(rd_addr))
    else $error("read address moved before acknowledge");
  a_route_excl: assert property (@(posedge core_clk) disable iff (rst)
    (act_req & cpu_irq) == '0)
    else $error("source routed both ways");
  a_upper_byte: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_VEC && rd_ack) |=> rd_addr == {8'hFF, $past(rd_data[15:0])})
    else $error("descriptor address upper byte wrong");
  a_ptr_then_desc: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_VEC && rd_ack) |=> state_q == S_DESC && !rd_word)
    else $error("descriptor read did not follow pointer");
  a_word_step: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_DESC && rd_ack && word_q != W_CNT_B) |=> rd_addr == $past(rd_addr) + 24'h4)
    else $error("descriptor word address step wrong");
  a_six_words: assert property (@(posedge core_clk) disable iff (rst)
    desc_valid |-> $past(word_q) == W_CNT_B)
    else $error("descriptor complete before six words");
  a_none_idle: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == S_IDLE && !sw_enable && act_req == '0) |=> state_q == S_IDLE)
    else $error("lookup started with no request");
  c_sw: cover property (@(posedge core_clk) disable iff (rst) desc_valid && desc_sw);
  c_hw: cover property (@(posedge core_clk) disable iff (rst) desc_valid && !desc_sw);
  c_both: cover property (@(posedge core_clk) disable iff (rst)
    state_q == S_IDLE && sw_enable && hw_hit);
  c_fault: cover property (@(posedge core_clk) disable iff (rst) desc_valid && desc_fault);
  c_adc: cover property (@(posedge core_clk) disable iff (rst) desc_valid && desc_src == 6'(ADC_SRC_IDX));
endmodule

// [core/xfer_vec_pkg.sv]
package xfer_vec_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0400;
  localparam logic [7:0] DESC_UPPER = 8'hFF;
  localparam logic [23:0] RAM_LO = 24'hFFEBC0;
  localparam logic [23:0] RAM_HI = 24'hFFEFBF;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  // ----------------------------------------------------------------
  // descriptor layout, word index from start
  // ----------------------------------------------------------------
  localparam int DESC_WORDS = 6;
  localparam logic [2:0] W_MODE_A = 3'h0;
  localparam logic [2:0] W_SRC = 3'h1;
  localparam logic [2:0] W_MODE_B = 3'h2;
  localparam logic [2:0] W_DST = 3'h3;
  localparam logic [2:0] W_CNT_A = 3'h4;
  localparam logic [2:0] W_CNT_B = 3'h5;
  // ----------------------------------------------------------------
  // hardware sources, highest priority first
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 46;
  localparam int ADC_SRC_IDX = 8;
  localparam logic [6:0] ADC_VEC_NUM = 7'h1C;
  localparam logic [6:0] SRC_VEC [NUM_SRC] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h1C, 7'h20, 7'h21, 7'h22, 7'h23, 7'h28, 7'h29, 7'h2C,
    7'h2D, 7'h30, 7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3C,
    7'h3D, 7'h40, 7'h41, 7'h44, 7'h45, 7'h51, 7'h52, 7'h55,
    7'h56, 7'h59, 7'h5A, 7'h5C, 7'h5D, 7'h60, 7'h61, 7'h69,
    7'h6A, 7'h6D, 7'h79, 7'h7A, 7'h7D, 7'h7E};
  localparam int SERIAL4_TX_IDX = 45;
  localparam int SERIAL4_TX_VEC = 126;
  localparam logic [1:0] OFF_SRC = 2'h0;
endpackage

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench
  import xfer_vec_pkg::*;
;
  logic core_clk, rst, adc_done_request, adc_done_enable, sw_enable, desc_taken, bad_ptr;
  logic [NUM_SRC-1:0] src_req, activation_enable_bit;
  logic [6:0] soft_vector_reg;
  logic [1:0] lat;
  logic [NUM_SRC-1:0] cpu_irq;
  logic rd_req, rd_word, rd_ack, busy, desc_valid, desc_sw, desc_fault;
  logic [23:0] rd_addr, desc_start, vec_seen;
  logic [31:0] rd_data, wa, sp, wb, dp, ca, cb;
  logic [5:0] desc_src;
  int n_errors = 0;
  int checks_done = 0;
  typedef struct {bit sw; logic [6:0] n; int src; logic [15:0] vec;} row_s;
  row_s rows [7] = '{'{1, 7'h10, 0, 16'h0420}, '{1, 7'h00, 0, 16'h0400},
    '{1, 7'h7F, 0, 16'h04FE}, '{0, 7'h00, 0, 16'h0420}, '{0, 7'h00, 7, 16'h042E},
    '{0, 7'h00, 8, 16'h0438}, '{0, 7'h00, 45, 16'h04FC}};
  xfer_vec_lookup DUT (.core_clk(core_clk), .rst(rst), .src_req(src_req),
    .activation_enable_bit(activation_enable_bit), .adc_done_request(adc_done_request),
    .adc_done_enable(adc_done_enable), .sw_enable(sw_enable),
    .soft_vector_reg(soft_vector_reg), .cpu_irq(cpu_irq), .rd_req(rd_req),
    .rd_word(rd_word), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .busy(busy),
    .desc_valid(desc_valid), .desc_sw(desc_sw), .desc_src(desc_src),
    .desc_start(desc_start), .desc_fault(desc_fault), .transfer_mode_word_a(wa),
    .source_pointer_word(sp), .transfer_mode_word_b(wb), .dest_pointer_word(dp),
    .count_word_a(ca), .count_word_b(cb), .desc_taken(desc_taken));
  xfer_mem_model mem (.core_clk(core_clk), .rst(rst), .rd_req(rd_req), .rd_word(rd_word),
    .rd_addr(rd_addr), .lat(lat), .bad_ptr(bad_ptr), .rd_ack(rd_ack), .rd_data(rd_data),
    .vec_seen(vec_seen));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task lookup(input bit sw, input int s, input logic [15:0] v, input bit f);
    logic [23:0] st;
    logic [31:0] w [6];
    int k;
    st = {8'hFF, (16'hEC00 + {6'h0, v[8:0], 1'b0}) | {14'h0, f, 1'b0}};
    k = 0;
    while (k < 100 && desc_valid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k == 100) begin
      chk(1'b0, "no descriptor");
      wrap_up;
    end
    w = '{wa, sp, wb, dp, ca, cb};
    chk(vec_seen === {8'h00, v}, "vector address");
    chk(desc_start === st, "start address");
    for (k = 0; k < 6; k++) chk(w[k] === {8'hA5, st + 24'(4 * k)}, "descriptor word");
    chk(desc_sw === sw && (sw || desc_src === s[5:0]), "winner");
    chk(desc_fault === f, "fault flag");
    // only the winner lets go; losers stay pending
    if (sw) sw_enable = 1'b0;
    else if (s == 8) adc_done_request = 1'b0;
    else src_req[s] = 1'b0;
    @(posedge core_clk);
    #1;
    desc_taken = 1'b1;
    @(posedge core_clk);
    #1;
    desc_taken = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    src_req = '0;
    activation_enable_bit = '1;
    adc_done_request = 1'b0;
    adc_done_enable = 1'b1;
    sw_enable = 1'b0;
    soft_vector_reg = 7'h00;
    desc_taken = 1'b0;
    bad_ptr = 1'b0;
    lat = 2'h0;
    repeat (6) @(posedge core_clk);
    #1;
    chk(rd_req === 1'b0 && busy === 1'b0 && desc_valid === 1'b0, "reset");
    rst = 1'b0;
    foreach (rows[i]) begin
      lat = 2'(i);
      if (rows[i].sw) begin
        soft_vector_reg = rows[i].n;
        sw_enable = 1'b1;
      end else if (rows[i].src == 8) adc_done_request = 1'b1;
      else src_req[rows[i].src] = 1'b1;
      lookup(rows[i].sw, rows[i].src, rows[i].vec, 1'b0);
    end
    src_req[45] = 1'b1;
    src_req[0] = 1'b1;
    soft_vector_reg = 7'h05;
    sw_enable = 1'b1;
    lookup(1'b1, 0, 16'h040A, 1'b0);
    lookup(1'b0, 0, 16'h0420, 1'b0);
    lookup(1'b0, 45, 16'h04FC, 1'b0);
    adc_done_enable = 1'b0;
    activation_enable_bit[3] = 1'b0;
    adc_done_request = 1'b1;
    src_req[3] = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(busy === 1'b0 && rd_req === 1'b0, "disabled source started");
    chk(cpu_irq[8] === 1'b1 && cpu_irq[3] === 1'b1, "cpu routing");
    activation_enable_bit[3] = 1'b1;
    lookup(1'b0, 3, 16'h0426, 1'b0);
    adc_done_request = 1'b0;
    bad_ptr = 1'b1;
    soft_vector_reg = 7'h20;
    sw_enable = 1'b1;
    lookup(1'b1, 0, 16'h0440, 1'b1);
    wrap_up;
  end
endmodule

// [verification/xfer_mem_model.sv]
`timescale 1ns/10ps
module xfer_mem_model (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic rd_req, // read request
  input wire logic rd_word, // pointer read
  input wire logic [23:0] rd_addr, // address
  input wire logic [1:0] lat, // wait cycles
  input wire logic bad_ptr, // misalign the pointer
  output logic rd_ack, // data valid
  output logic [31:0] rd_data, // read data
  output logic [23:0] vec_seen // last pointer address
);
  logic [1:0] cnt_q;
  logic [15:0] ptr;
  // descriptor pointers from EC00, four bytes apart per vector number
  assign ptr = (16'hEC00 + {6'h0, rd_addr[8:0], 1'b0}) | {14'h0, bad_ptr, 1'b0};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_ack <= 1'b0;
      cnt_q <= 2'h0;
      rd_data <= 32'h0;
      vec_seen <= 24'h0;
    end else if (rd_ack) begin
      rd_ack <= 1'b0;
      cnt_q <= 2'h0;
      rd_data <= ~rd_data;
    end else if (rd_req && cnt_q >= lat) begin
      rd_ack <= 1'b1;
      // word content names its own address so order shows
      rd_data <= rd_word ? {16'h0, ptr} : {8'hA5, rd_addr};
      if (rd_word) begin
        vec_seen <= rd_addr;
      end
    end else begin
      cnt_q <= cnt_q + {1'b0, rd_req};
      // stale data never looks valid
      rd_data <= ~rd_data;
    end
  end
endmodule
